// ---- servo_seq_pkg.sv ----
// Constants shared by the sequence I/O block
package servo_seq_pkg;
   localparam int unsigned CLK_HZ       = 200_000_000;
   localparam int unsigned WARN_PULSE_S = 2;
   localparam int unsigned WARN_PULSE_CYC = WARN_PULSE_S * CLK_HZ;
   localparam int unsigned DEBOUNCE_US  = 1000;
   localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
   localparam int          CNT_W        = 32;

   // Contact input positions in the synchronised vector
   localparam int IN_MODE  = 0;
   localparam int IN_START = 1;
   localparam int IN_RESET = 2;
   localparam int IN_OT_F  = 3;
   localparam int IN_OT_R  = 4;
   localparam int IN_ACLR  = 5;
   localparam int IN_DEC   = 6;
   localparam int IN_LATCH = 7;
   localparam int IN_SON   = 8;
   localparam int IN_PICK  = 9;
   localparam int NIN      = 17;

   // Register byte offsets
   localparam logic [3:0] CTRL_OFS  = 4'h0;
   localparam logic [3:0] STAT_OFS  = 4'h4;
   localparam logic [3:0] LATCH_OFS = 4'h8;
   localparam logic [3:0] INPUT_OFS = 4'hC;

   // Field positions
   localparam int CTRL_CODE_BIT = 0;
   localparam int CTRL_DONE_BIT = 1;
   localparam int ST_LVALID_BIT = 8;

   localparam logic       CTRL_CODE_RST = 1'b0;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   typedef enum logic [1:0] {T_IDLE, T_RUN, T_PAUSE} table_state_t;
endpackage

// ---- servo_indexer_sequence_io.sv ----
// Sequence contact I/O logic of the positioning indexer with AXI4-Lite registers
`timescale 1ns/100ps

module servo_indexer_sequence_io #(
   parameter int unsigned DEBOUNCE_CYCLES = servo_seq_pkg::DEBOUNCE_CYC,
   parameter int unsigned WARN_CYCLES     = servo_seq_pkg::WARN_PULSE_CYC,
   parameter int          POS_W           = 32
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             ce,
   input  wire logic [3:0]       awaddr,
   input  wire logic             awvalid,
   output      logic             awready,
   input  wire logic [31:0]      wdata,
   input  wire logic [3:0]       wstrb,
   input  wire logic             wvalid,
   output      logic             wready,
   output      logic [1:0]       bresp,
   output      logic             bvalid,
   input  wire logic             bready,
   input  wire logic [3:0]       araddr,
   input  wire logic             arvalid,
   output      logic             arready,
   output      logic [31:0]      rdata,
   output      logic [1:0]       rresp,
   output      logic             rvalid,
   input  wire logic             rready,
   input  wire logic             mode_select_in,
   input  wire logic             start_stop_in,
   input  wire logic             table_reset_in,
   input  wire logic [7:0]       table_pick_in,
   input  wire logic             forward_overtravel,
   input  wire logic             reverse_overtravel,
   input  wire logic             alarm_clear_in,
   input  wire logic             homing_slowdown_switch,
   input  wire logic             position_latch_in,
   input  wire logic             servo_on_in,
   input  wire logic [POS_W-1:0] position_in,
   input  wire logic             fault_detect,
   input  wire logic             warning_detect,
   input  wire logic             ctrl_power_ok,
   input  wire logic             main_power_ok,
   input  wire logic             brake_release_req,
   input  wire logic [2:0]       fault_code_in,
   output      logic             fault_out,
   output      logic             status_out_1,
   output      logic             status_out_2,
   output      logic             status_out_3,
   output      logic             brake_release_out,
   output      logic             motor_power_en,
   output      logic             table_run,
   output      logic [7:0]       table_select,
   output      logic             table_reset_pulse,
   output      logic             homing_run,
   output      logic             homing_slow,
   output      logic             forward_manual_move,
   output      logic             reverse_manual_move,
   output      logic [3:0]       manual_speed_pick,
   output      logic             forward_stop,
   output      logic             reverse_stop,
   output      logic [POS_W-1:0] latch_position
);
   localparam int NIN   = servo_seq_pkg::NIN;
   localparam int CNT_W = servo_seq_pkg::CNT_W;

   typedef struct packed {
      logic [NIN-1:0]             sync1;
      logic [NIN-1:0]             sync2;
      logic [NIN-1:0]             samp;
      logic [NIN-1:0]             filt;
      logic [NIN-1:0]             prev;
      logic [CNT_W-1:0]           deb_cnt;
      logic [CNT_W-1:0]           warn_cnt;
      servo_seq_pkg::table_state_t tstate;
      logic [7:0]                 tsel;
      logic                       treset_p;
      logic                       homing;
      logic                       hslow;
      logic                       jogf;
      logic                       jogr;
      logic                       fstop;
      logic                       rstop;
      logic                       alarm;
      logic                       warn;
      logic                       mpower;
      logic                       ready;
      logic                       brake;
      logic [3:0]                 speed;
      logic [2:0]                 so;
      logic [POS_W-1:0]           lpos;
      logic                       lvalid;
      logic                       code_mode;
      logic                       aw_ok;
      logic                       w_ok;
      logic                       bvalid;
      logic                       rvalid;
      logic [3:0]                 awaddr;
      logic [31:0]                wdata;
      logic [3:0]                 wstrb;
      logic [1:0]                 bresp;
      logic [1:0]                 rresp;
      logic [31:0]                rdata;
   } state_t;

   state_t s_reg;
   state_t s_next;

   logic [NIN-1:0] pins;
   logic [NIN-1:0] rise;
   logic [NIN-1:0] stable;
   logic           mode0;
   logic           start;
   logic           start_rise;
   logic           tbl_reset;
   logic [7:0]     pick;
   logic           ot_f;
   logic           ot_r;
   logic           aclr_rise;
   logic           latch_rise;
   logic           son;
   logic           do_wr;
   logic           done_wr;
   logic           lvalid_clr;
   logic [31:0]    status_word;

   function automatic logic reg_mapped(input logic [3:0] a);
      reg_mapped = (a == servo_seq_pkg::CTRL_OFS) || (a == servo_seq_pkg::STAT_OFS) ||
                   (a == servo_seq_pkg::LATCH_OFS) || (a == servo_seq_pkg::INPUT_OFS);
   endfunction

   assign pins = {table_pick_in, servo_on_in, position_latch_in, homing_slowdown_switch,
                  alarm_clear_in, reverse_overtravel, forward_overtravel, table_reset_in,
                  start_stop_in, mode_select_in};

   // Debounced levels and rising edges
   assign rise       = s_reg.filt & ~s_reg.prev;
   assign mode0      = s_reg.filt[servo_seq_pkg::IN_MODE];
   assign start      = s_reg.filt[servo_seq_pkg::IN_START];
   assign start_rise = rise[servo_seq_pkg::IN_START];
   assign tbl_reset  = s_reg.filt[servo_seq_pkg::IN_RESET];
   assign pick       = s_reg.filt[servo_seq_pkg::IN_PICK +: 8];
   assign ot_f       = s_reg.filt[servo_seq_pkg::IN_OT_F];
   assign ot_r       = s_reg.filt[servo_seq_pkg::IN_OT_R];
   assign aclr_rise  = rise[servo_seq_pkg::IN_ACLR];
   assign latch_rise = rise[servo_seq_pkg::IN_LATCH];
   assign son        = s_reg.filt[servo_seq_pkg::IN_SON];
   assign stable     = ~(s_reg.sync2 ^ s_reg.samp);

   // Register write decode
   assign do_wr      = s_reg.aw_ok && s_reg.w_ok && !s_reg.bvalid;
   assign done_wr    = do_wr && (s_reg.awaddr == servo_seq_pkg::CTRL_OFS) && s_reg.wstrb[0] &&
                       s_reg.wdata[servo_seq_pkg::CTRL_DONE_BIT];
   assign lvalid_clr = do_wr && (s_reg.awaddr == servo_seq_pkg::STAT_OFS) && s_reg.wstrb[1] &&
                       s_reg.wdata[servo_seq_pkg::ST_LVALID_BIT];

   assign status_word = {4'h0, s_reg.speed, s_reg.tsel, 5'h00, s_reg.mpower, s_reg.ready,
                         s_reg.lvalid, s_reg.warn, s_reg.alarm, s_reg.jogr, s_reg.jogf,
                         s_reg.homing, s_reg.tstate, mode0};

   always_comb begin
      s_next = s_reg;
      // Two-stage synchroniser, then debounce by two equal spaced samples
      s_next.sync1 = pins;
      s_next.sync2 = s_reg.sync1;
      s_next.prev  = s_reg.filt;
      if (s_reg.deb_cnt >= CNT_W'(DEBOUNCE_CYCLES - 1)) begin
         s_next.deb_cnt = '0;
         s_next.samp    = s_reg.sync2;
         s_next.filt    = (stable & s_reg.sync2) | (~stable & s_reg.filt);
      end else begin
         s_next.deb_cnt = s_reg.deb_cnt + CNT_W'(1);
      end

      // Program table sequencing
      s_next.treset_p = 1'b0;
      case (s_reg.tstate)
         servo_seq_pkg::T_IDLE: begin
            if (mode0 && start_rise && !s_reg.alarm) begin
               s_next.tstate = servo_seq_pkg::T_RUN;
               s_next.tsel   = pick;
            end
         end
         servo_seq_pkg::T_RUN: begin
            if (done_wr) begin
               s_next.tstate = servo_seq_pkg::T_IDLE;
            end else if (!mode0 || !start || s_reg.alarm) begin
               s_next.tstate = servo_seq_pkg::T_PAUSE;
            end
         end
         servo_seq_pkg::T_PAUSE: begin
            if (mode0 && !start && tbl_reset) begin
               s_next.tstate   = servo_seq_pkg::T_IDLE;
               s_next.treset_p = 1'b1;
            end else if (mode0 && start && !s_reg.alarm) begin
               s_next.tstate = servo_seq_pkg::T_RUN;
            end
         end
         default: begin
            s_next.tstate = servo_seq_pkg::T_IDLE;
         end
      endcase

      // Homing and jog in mode 1
      s_next.homing = !mode0 && start && !s_reg.alarm;
      s_next.hslow  = s_next.homing && s_reg.filt[servo_seq_pkg::IN_DEC];
      s_next.jogf   = !mode0 && tbl_reset && !ot_f && !s_reg.alarm;
      s_next.jogr   = !mode0 && pick[0] && !ot_r && !s_reg.alarm;
      if (!mode0) begin
         s_next.speed = pick[4:1];
      end
      s_next.fstop = ot_f;
      s_next.rstop = ot_r;

      // Position latch, set wins over clear
      if (lvalid_clr) begin
         s_next.lvalid = 1'b0;
      end
      if (latch_rise) begin
         s_next.lpos   = position_in;
         s_next.lvalid = 1'b1;
      end

      // Alarm, warning and power
      if (fault_detect) begin
         s_next.alarm = 1'b1;
      end else if (aclr_rise) begin
         s_next.alarm = 1'b0;
      end
      if (!s_reg.alarm && fault_detect) begin
         s_next.warn_cnt = CNT_W'(WARN_CYCLES);
      end else if (s_reg.warn_cnt != '0) begin
         s_next.warn_cnt = s_reg.warn_cnt - CNT_W'(1);
      end
      s_next.warn   = (s_next.warn_cnt != '0) || warning_detect;
      s_next.mpower = son && !s_next.alarm;
      s_next.ready  = ctrl_power_ok && main_power_ok && !s_next.alarm;
      s_next.brake  = brake_release_req;
      if (s_next.code_mode) begin
         s_next.so = fault_code_in;
      end else begin
         s_next.so = {s_next.ready, s_next.brake, s_next.warn};
      end

      // AXI4-Lite write path
      if (awvalid && awready) begin
         s_next.aw_ok  = 1'b1;
         s_next.awaddr = awaddr;
      end
      if (wvalid && wready) begin
         s_next.w_ok  = 1'b1;
         s_next.wdata = wdata;
         s_next.wstrb = wstrb;
      end
      if (do_wr) begin
         s_next.aw_ok  = 1'b0;
         s_next.w_ok   = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp  = reg_mapped(s_reg.awaddr) ? servo_seq_pkg::RESP_OKAY :
                                                    servo_seq_pkg::RESP_SLVERR;
         if (s_reg.awaddr == servo_seq_pkg::CTRL_OFS && s_reg.wstrb[0]) begin
            s_next.code_mode = s_reg.wdata[servo_seq_pkg::CTRL_CODE_BIT];
         end
      end else if (s_reg.bvalid && bready) begin
         s_next.bvalid = 1'b0;
      end

      // AXI4-Lite read path
      if (arvalid && arready) begin
         s_next.rvalid = 1'b1;
         s_next.rresp  = reg_mapped(araddr) ? servo_seq_pkg::RESP_OKAY :
                                              servo_seq_pkg::RESP_SLVERR;
         case (araddr)
            servo_seq_pkg::CTRL_OFS:  s_next.rdata = {31'h00000000, s_reg.code_mode};
            servo_seq_pkg::STAT_OFS:  s_next.rdata = status_word;
            servo_seq_pkg::LATCH_OFS: s_next.rdata = 32'(s_reg.lpos);
            servo_seq_pkg::INPUT_OFS: s_next.rdata = 32'(s_reg.filt);
            default:                  s_next.rdata = 32'h00000000;
         endcase
      end else if (s_reg.rvalid && rready) begin
         s_next.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg           <= '0;
         s_reg.code_mode <= servo_seq_pkg::CTRL_CODE_RST;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign awready             = !s_reg.aw_ok && !s_reg.bvalid;
   assign wready              = !s_reg.w_ok && !s_reg.bvalid;
   assign bvalid              = s_reg.bvalid;
   assign bresp               = s_reg.bresp;
   assign arready             = !s_reg.rvalid;
   assign rvalid              = s_reg.rvalid;
   assign rdata               = s_reg.rdata;
   assign rresp               = s_reg.rresp;
   assign fault_out           = !s_reg.alarm;
   assign status_out_1        = s_reg.so[0];
   assign status_out_2        = s_reg.so[1];
   assign status_out_3        = s_reg.so[2];
   assign brake_release_out   = s_reg.brake;
   assign motor_power_en      = s_reg.mpower;
   assign table_run           = (s_reg.tstate == servo_seq_pkg::T_RUN);
   assign table_select        = s_reg.tsel;
   assign table_reset_pulse   = s_reg.treset_p;
   assign homing_run          = s_reg.homing;
   assign homing_slow         = s_reg.hslow;
   assign forward_manual_move = s_reg.jogf;
   assign reverse_manual_move = s_reg.jogr;
   assign manual_speed_pick   = s_reg.speed;
   assign forward_stop        = s_reg.fstop;
   assign reverse_stop        = s_reg.rstop;
   assign latch_position      = s_reg.lpos;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_start;
      ce && s_reg.tstate == servo_seq_pkg::T_IDLE && mode0 && start_rise && !s_reg.alarm
      |=> table_run && table_select == $past(pick);
   endproperty
   a_start: assert property (p_start) else $error("table start failed");

   property p_stop;
      ce && table_run && !done_wr && !start |=> s_reg.tstate == servo_seq_pkg::T_PAUSE;
   endproperty
   a_stop: assert property (p_stop) else $error("table not interrupted");

   property p_mode;
      ce && table_run && !done_wr && !mode0 |=> !table_run;
   endproperty
   a_mode: assert property (p_mode) else $error("table ran outside mode 0");

   property p_reset;
      ce && s_reg.tstate == servo_seq_pkg::T_PAUSE && mode0 && !start && tbl_reset
      |=> s_reg.tstate == servo_seq_pkg::T_IDLE && table_reset_pulse ##1 !table_reset_pulse;
   endproperty
   a_reset: assert property (p_reset) else $error("table reset wrong");

   property p_home;
      ce && !mode0 |=> homing_run == $past(start && !s_reg.alarm);
   endproperty
   a_home: assert property (p_home) else $error("homing does not follow start");

   property p_jog;
      ce && !mode0 && !s_reg.alarm |=> forward_manual_move == $past(tbl_reset && !ot_f) &&
                                      reverse_manual_move == $past(pick[0] && !ot_r);
   endproperty
   a_jog: assert property (p_jog) else $error("jog level wrong");

   property p_ot;
      ce && ot_f |=> !forward_manual_move && forward_stop;
   endproperty
   a_ot: assert property (p_ot) else $error("forward overtravel ignored");

   property p_speed;
      ce && !mode0 |=> manual_speed_pick == $past(pick[4:1]);
   endproperty
   a_speed: assert property (p_speed) else $error("jog speed selection wrong");

   property p_fault;
      ce && fault_detect |=> !fault_out && !motor_power_en;
   endproperty
   a_fault: assert property (p_fault) else $error("fault not flagged");

   property p_clear;
      ce && s_reg.alarm && !fault_detect && aclr_rise |=> fault_out;
   endproperty
   a_clear: assert property (p_clear) else $error("alarm not cleared");

   property p_warn;
      ce && !s_reg.alarm && fault_detect |=> s_reg.warn_cnt == CNT_W'(WARN_CYCLES) && s_reg.warn;
   endproperty
   a_warn: assert property (p_warn) else $error("warning pulse not started");

   property p_ready;
      ce && !(ctrl_power_ok && main_power_ok) |=> !s_reg.ready;
   endproperty
   a_ready: assert property (p_ready) else $error("ready without power");

   property p_latch;
      ce && latch_rise |=> latch_position == $past(position_in) && s_reg.lvalid;
   endproperty
   a_latch: assert property (p_latch) else $error("position not latched");

   property p_assign;
      ce && s_reg.code_mode && !do_wr
      |=> {status_out_3, status_out_2, status_out_1} == $past(fault_code_in);
   endproperty
   a_assign: assert property (p_assign) else $error("alarm code not routed");

   c_run:    cover property (ce && s_reg.tstate == servo_seq_pkg::T_PAUSE && start && mode0);
   c_home:   cover property (homing_run && homing_slow);
   c_clear:  cover property (s_reg.alarm ##1 !s_reg.alarm);
   c_rdwr:   cover property (bvalid && rvalid);
endmodule

// ---- host_contacts.sv ----
// Host controller model: relay contacts that bounce after each change
`timescale 1ns/100ps
module host_contacts #(
   parameter int BOUNCE = 5
) (
   input  wire logic        aclk,
   input  wire logic [16:0] want,
   output      logic        mode_select_in,
   output      logic        start_stop_in,
   output      logic        table_reset_in,
   output      logic        forward_overtravel,
   output      logic        reverse_overtravel,
   output      logic        alarm_clear_in,
   output      logic        homing_slowdown_switch,
   output      logic        position_latch_in,
   output      logic        servo_on_in,
   output      logic [7:0]  table_pick_in
);
   logic [16:0] last_reg = '0;
   logic [16:0] diff_reg = '0;
   logic [16:0] pins_reg = '0;
   int          bcnt     = 0;
   // Changed contacts chatter back to the old level in two-cycle bursts
   always @(posedge aclk) begin
      if (want !== last_reg) begin
         diff_reg <= want ^ last_reg;
         last_reg <= want;
         bcnt     <= BOUNCE;
      end else if (bcnt != 0) begin
         bcnt <= bcnt - 1;
      end
      pins_reg <= bcnt[1] ? (last_reg ^ diff_reg) : last_reg;
   end
   assign {table_pick_in, servo_on_in, position_latch_in, homing_slowdown_switch,
           alarm_clear_in, reverse_overtravel, forward_overtravel, table_reset_in,
           start_stop_in, mode_select_in} = pins_reg;
endmodule

// ---- servo_indexer_sequence_io_tb.sv ----
// Self-checking bench for the sequence I/O block
`timescale 1ns/100ps
module servo_indexer_sequence_io_tb;
   typedef struct packed {logic [16:0] in; logic [19:0] ex;} row_t;
   logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, fault_detect = 0, warning_detect = 0;
   logic ctrl_power_ok = 1, main_power_ok = 1, brake_release_req = 0;
   logic [3:0]  awaddr = '0, araddr = '0, wstrb = 4'hF;
   logic [31:0] wdata = '0, position_in = '0, rd;
   logic [2:0]  fault_code_in = '0;
   logic [16:0] want = '0;
   logic [1:0]  bresp, rresp, rs;
   logic [31:0] rdata, latch_position;
   logic [7:0]  table_select, table_pick_in;
   logic [3:0]  manual_speed_pick;
   logic awready, wready, bvalid, arready, rvalid, fault_out, status_out_1, status_out_2;
   logic status_out_3, brake_release_out, motor_power_en, table_run, table_reset_pulse;
   logic homing_run, homing_slow, forward_manual_move, reverse_manual_move;
   logic forward_stop, reverse_stop, mode_select_in, start_stop_in, table_reset_in;
   logic forward_overtravel, reverse_overtravel, alarm_clear_in, homing_slowdown_switch;
   logic position_latch_in, servo_on_in;
   int   fails = 0, n_checks = 0, cyc = 0;
   logic [31:0] k;
   row_t rows[12];

   servo_indexer_sequence_io #(.DEBOUNCE_CYCLES(4), .WARN_CYCLES(20)) DUT (
      .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .mode_select_in(mode_select_in), .start_stop_in(start_stop_in),
      .table_reset_in(table_reset_in), .table_pick_in(table_pick_in),
      .forward_overtravel(forward_overtravel), .reverse_overtravel(reverse_overtravel),
      .alarm_clear_in(alarm_clear_in), .homing_slowdown_switch(homing_slowdown_switch),
      .position_latch_in(position_latch_in), .servo_on_in(servo_on_in),
      .position_in(position_in), .fault_detect(fault_detect), .warning_detect(warning_detect),
      .ctrl_power_ok(ctrl_power_ok), .main_power_ok(main_power_ok),
      .brake_release_req(brake_release_req), .fault_code_in(fault_code_in),
      .fault_out(fault_out), .status_out_1(status_out_1), .status_out_2(status_out_2),
      .status_out_3(status_out_3), .brake_release_out(brake_release_out),
      .motor_power_en(motor_power_en), .table_run(table_run), .table_select(table_select),
      .table_reset_pulse(table_reset_pulse), .homing_run(homing_run),
      .homing_slow(homing_slow), .forward_manual_move(forward_manual_move),
      .reverse_manual_move(reverse_manual_move), .manual_speed_pick(manual_speed_pick),
      .forward_stop(forward_stop), .reverse_stop(reverse_stop),
      .latch_position(latch_position));
   host_contacts host (
      .aclk(aclk), .want(want), .mode_select_in(mode_select_in),
      .start_stop_in(start_stop_in), .table_reset_in(table_reset_in),
      .forward_overtravel(forward_overtravel), .reverse_overtravel(reverse_overtravel),
      .alarm_clear_in(alarm_clear_in), .homing_slowdown_switch(homing_slowdown_switch),
      .position_latch_in(position_latch_in), .servo_on_in(servo_on_in),
      .table_pick_in(table_pick_in));

   always #2.5 aclk = ~aclk;

   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      logic aw, w, b;
      aw = 1; w = 1; b = 1;
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      while (b) begin
         @(posedge aclk);
         if (aw && awready) begin aw = 0; awvalid <= 0; end
         if (w && wready) begin w = 0; wvalid <= 0; end
         if (bvalid) begin b = 0; rs = bresp; bready <= 0; end
      end
   endtask

   task automatic axi_rd(input logic [3:0] a);
      logic ar, r;
      ar = 1; r = 1;
      araddr <= a; arvalid <= 1; rready <= 1;
      while (r) begin
         @(posedge aclk);
         if (ar && arready) begin ar = 0; arvalid <= 0; end
         if (rvalid) begin r = 0; rd = rdata; rs = rresp; rready <= 0; end
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 6000) begin
         fails++;
         report_and_stop();
      end
   end

   initial begin
      rows = '{'{17'h14B01, 20'h02000}, '{17'h14B03, 20'h82A50}, '{17'h07903, 20'h82A50},
               '{17'h07907, 20'h82A50}, '{17'h14B01, 20'h02A50}, '{17'h14B03, 20'h82A50},
               '{17'h1ED04, 20'h22A5B}, '{17'h01542, 20'h43A55}, '{17'h01700, 20'h12A55},
               '{17'h00108, 20'h0AA50}, '{17'h00110, 20'h06A50}, '{17'h00000, 20'h00A50}};
      settle(20);
      chk({fault_out, table_run, awready, wready, status_out_1}, 5'h16);
      aresetn <= 1;
      foreach (rows[i]) begin
         want <= rows[i].in;
         settle(40);
         chk({table_run, homing_run, forward_manual_move, reverse_manual_move, forward_stop,
              reverse_stop, motor_power_en, homing_slow, table_select, manual_speed_pick},
             rows[i].ex);
      end
      want <= 17'h07905;
      k = 0;
      repeat (40) begin @(posedge aclk); k += table_reset_pulse; end
      chk(k, 1);
      axi_rd(servo_seq_pkg::STAT_OFS);
      chk(rd[2:1], 2'h0);
      want <= 17'h07903;
      settle(40);
      chk({table_run, table_select}, 9'h13C);
      axi_wr(servo_seq_pkg::CTRL_OFS, 32'h2);
      settle(2);
      chk({rs, table_run}, 3'h0);
      want <= 17'h07901;
      settle(40);
      want <= 17'h07903;
      settle(1);
      want <= 17'h07901;
      settle(40);
      chk(table_run, 1'b0);
      position_in <= 32'h1234ABCD;
      want <= 17'h07981;
      settle(40);
      axi_rd(servo_seq_pkg::LATCH_OFS);
      chk(rd, 32'h1234ABCD);
      chk(latch_position, 32'h1234ABCD);
      settle(1);
      axi_rd(servo_seq_pkg::STAT_OFS);
      chk(rd[8], 1'b1);
      axi_wr(servo_seq_pkg::STAT_OFS, 32'h100);
      axi_rd(servo_seq_pkg::STAT_OFS);
      chk(rd[8], 1'b0);
      fault_detect <= 1;
      settle(1);
      fault_detect <= 0;
      k = 0;
      repeat (40) begin @(posedge aclk); k += status_out_1; end
      chk(k, 20);
      chk({fault_out, motor_power_en, status_out_3}, 3'h0);
      want <= 17'h079A1;
      settle(40);
      chk({fault_out, status_out_3, motor_power_en}, 3'h7);
      ce <= 0;
      fault_detect <= 1;
      settle(3);
      chk({fault_out, motor_power_en}, 2'h3);
      fault_detect <= 0;
      ce <= 1;
      main_power_ok <= 0;
      settle(3);
      chk(status_out_3, 1'b0);
      main_power_ok <= 1;
      warning_detect <= 1;
      brake_release_req <= 1;
      settle(3);
      chk({status_out_1, status_out_2, brake_release_out}, 3'h7);
      brake_release_req <= 0;
      fault_code_in <= 3'b010;
      axi_wr(servo_seq_pkg::CTRL_OFS, 32'h1);
      settle(3);
      chk({status_out_3, status_out_2, status_out_1}, 3'b010);
      axi_rd(servo_seq_pkg::CTRL_OFS);
      chk(rd, 32'h1);
      axi_wr(4'h2, 32'hFFFFFFFF);
      chk(rs, servo_seq_pkg::RESP_SLVERR);
      axi_rd(4'h3);
      chk({rs, rd}, {servo_seq_pkg::RESP_SLVERR, 32'h0});
      axi_wr(servo_seq_pkg::INPUT_OFS, 32'h0);
      chk(rs, servo_seq_pkg::RESP_OKAY);
      axi_rd(servo_seq_pkg::INPUT_OFS);
      chk({rs, rd}, {servo_seq_pkg::RESP_OKAY, 32'h079A1});
      aresetn <= 0;
      settle(3);
      chk({fault_out, table_run, awready, wready, arready, status_out_1}, 6'h2E);
      aresetn <= 1;
      settle(2);
      chk({fault_out, bvalid, rvalid, table_run, motor_power_en}, 5'h10);
      report_and_stop();
   end
endmodule
